// ==== bdt_seq.sv ====
// Contract
// - only a passed condition transfers anything
// - list bit i selects register i
// - stored program_counter equals instruction address plus 12
// - ascending order, program_counter moved last
// - L load, P before, U increment
// - base changes only by write-back or load
// - S load with program_counter restores status word
// - S store reads the user bank
// - S load without program_counter writes user bank
// - write-back ends second cycle, first store starts it
// - loaded base beats written-back base
// - store abort runs on, then traps
// - load abort stops all later register loads
// - load abort restores base, traps at end
// - cycle counts fetch, n transfers, internal (+2)
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bdt_params.svh"

module bdt_seq
  import bdt_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output bdt_pkg::bdt_word_t    hrdata,
  output logic                  mem_req,
  output logic                  mem_we,
  output bdt_pkg::bdt_word_t    mem_addr,
  output bdt_pkg::bdt_word_t    mem_wdata,
  input  wire logic [31:0]      mem_rdata,
  input  wire logic             mem_abort,
  output bdt_pkg::bdt_idx_t     rf_base_idx,
  input  wire logic [31:0]      rf_base_data,
  output bdt_pkg::bdt_idx_t     rf_rd_idx,
  output logic                  rf_rd_user,
  input  wire logic [31:0]      rf_rd_data,
  output logic                  rf_wr_en,
  output bdt_pkg::bdt_idx_t     rf_wr_idx,
  output logic                  rf_wr_user,
  output bdt_pkg::bdt_word_t    rf_wr_data,
  output logic                  psr_restore,
  output logic                  busy,
  output logic                  done,
  output logic                  abort_trap
);
  import bdt_pkg::*;

  bdt_calc_if calc ();

  bdt_state_e  state_reg;
  bdt_word_t   instr_reg;
  logic        cond_reg;
  bdt_word_t   iaddr_reg;
  bdt_word_t   base_reg;
  bdt_word_t   wb_reg;
  bdt_word_t   lastbase_reg;
  bdt_list_t   pend_reg;
  bdt_idx_t    cur_idx_reg;
  logic        abort_seen_reg;
  logic        last_abort_reg;
  logic [1:0]  refill_reg;
  logic [7:0]  cyc_reg;
  logic [7:0]  cyc_last_reg;
  logic        ahb_wr_reg;
  logic [7:0]  ahb_addr_reg;
  logic        go_wr;
  logic        ab_now;
  logic        op_load;
  logic        op_s;
  logic        op_w;
  logic        pc_listed;
  bdt_idx_t    base_idx;
  bdt_list_t   pend_next;
  bdt_word_t   restore_val;

  ////////////////////////////////////////////////////////////////////////////
  // field meaning
  assign op_load   = instr_reg[`BDT_BIT_L];
  assign op_s      = instr_reg[`BDT_BIT_S];
  assign op_w      = instr_reg[`BDT_BIT_W];
  assign base_idx  = instr_reg[`BDT_BASE_MSB:`BDT_BASE_LSB];
  assign pc_listed = instr_reg[`BDT_LIST_MSB];
  assign pend_next = pend_reg & ~(16'h0001 << bdt_lowest(pend_reg));
  assign ab_now    = abort_seen_reg | mem_abort;
  // base goes back to the written-back or original value
  assign restore_val = op_w ? wb_reg : base_reg;

  assign calc.base = rf_base_data;
  assign calc.list = instr_reg[`BDT_LIST_MSB:0];
  assign calc.pre  = instr_reg[`BDT_BIT_P];
  assign calc.up   = instr_reg[`BDT_BIT_U];

  bdt_addr_calc u_calc (
    .c (calc.calc)
  );

  // program_counter stores as address plus 12
  // forward a write still in flight so a later base sees its new value
  function automatic bdt_word_t store_value(input bdt_idx_t idx, input bdt_word_t rd);
    bdt_word_t v;
    v = rd;
    if (idx == `BDT_PC_IDX) begin
      v = iaddr_reg + `BDT_PC_STORE_OFS;
    end else if (rf_wr_en && rf_wr_idx == idx && rf_wr_user == rf_rd_user) begin
      v = rf_wr_data;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always OKAY
  assign go_wr = ahb_wr_reg && ahb_addr_reg == `BDT_OFS_CTRL && hwdata[`BDT_CTRL_GO];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ahb_wr_reg   <= 1'b0;
      ahb_addr_reg <= 8'h00;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= `BDT_RST_WORD;
    end else begin
      ahb_wr_reg   <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      ahb_addr_reg <= haddr[7:0];
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `BDT_OFS_INSTR:    hrdata <= instr_reg;
          `BDT_OFS_CTRL:     hrdata <= {30'h0000_0000, cond_reg, 1'b0};
          `BDT_OFS_IADDR:    hrdata <= iaddr_reg;
          `BDT_OFS_STATUS:   hrdata <= {16'h0000, cyc_last_reg, 6'h00,
                                        last_abort_reg, state_reg != BDT_IDLE};
          `BDT_OFS_LASTBASE: hrdata <= lastbase_reg;
          default:           hrdata <= `BDT_RST_WORD;
        endcase
      end
    end
  end

  // writes to the set-up registers are dropped while a block is running
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      instr_reg <= `BDT_RST_WORD;
      cond_reg  <= 1'b0;
      iaddr_reg <= `BDT_RST_WORD;
    end else if (ahb_wr_reg && state_reg == BDT_IDLE) begin
      case (ahb_addr_reg)
        `BDT_OFS_INSTR: instr_reg <= hwdata;
        `BDT_OFS_CTRL:  cond_reg  <= hwdata[`BDT_CTRL_COND];
        `BDT_OFS_IADDR: iaddr_reg <= hwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and memory side
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg      <= BDT_IDLE;
      pend_reg       <= 16'h0000;
      cur_idx_reg    <= `BDT_RST_IDX;
      abort_seen_reg <= 1'b0;
      refill_reg     <= 2'h0;
      base_reg       <= `BDT_RST_WORD;
      wb_reg         <= `BDT_RST_WORD;
      mem_req        <= 1'b0;
      mem_we         <= 1'b0;
      mem_addr       <= `BDT_RST_WORD;
      mem_wdata      <= `BDT_RST_WORD;
      rf_base_idx    <= `BDT_RST_IDX;
      rf_rd_idx      <= `BDT_RST_IDX;
      rf_rd_user     <= 1'b0;
    end else begin
      case (state_reg)
        BDT_IDLE: begin
          abort_seen_reg <= 1'b0;
          // a failed condition retires with no effect
          // an empty list is treated the same way
          if (go_wr && hwdata[`BDT_CTRL_COND] && instr_reg[`BDT_LIST_MSB:0] != 16'h0000) begin
            state_reg   <= BDT_FETCH;
            pend_reg    <= instr_reg[`BDT_LIST_MSB:0];
            rf_base_idx <= base_idx;
            rf_rd_idx   <= bdt_lowest(instr_reg[`BDT_LIST_MSB:0]);
            // user bank source for privileged stores
            rf_rd_user  <= op_s && !op_load;
          end
        end
        BDT_FETCH: begin
          base_reg    <= rf_base_data;
          wb_reg      <= calc.wb_addr;
          // first transfer starts the second cycle
          state_reg   <= BDT_XFER;
          mem_req     <= 1'b1;
          mem_we      <= !op_load;
          mem_addr    <= calc.start_addr;
          mem_wdata   <= store_value(rf_rd_idx, rf_rd_data);
          cur_idx_reg <= bdt_lowest(pend_reg);
          pend_reg    <= pend_next;
          rf_rd_idx   <= bdt_lowest(pend_next);
        end
        BDT_XFER: begin
          // store aborts only get noted, the block runs on
          abort_seen_reg <= ab_now;
          if (pend_reg != 16'h0000) begin
            // next higher register, next higher word
            mem_addr    <= mem_addr + `BDT_WORD_BYTES;
            mem_wdata   <= store_value(rf_rd_idx, rf_rd_data);
            cur_idx_reg <= bdt_lowest(pend_reg);
            pend_reg    <= pend_next;
            rf_rd_idx   <= bdt_lowest(pend_next);
          end else begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            state_reg <= BDT_INTERNAL;
          end
        end
        BDT_INTERNAL: begin
          // pipeline refill after a program_counter load
          if (op_load && pc_listed && !abort_seen_reg) begin
            state_reg  <= BDT_REFILL;
            refill_reg <= `BDT_REFILL_CYC;
          end else begin
            state_reg  <= BDT_IDLE;
          end
        end
        BDT_REFILL: begin
          refill_reg <= refill_reg - 2'h1;
          if (refill_reg == 2'h1) begin
            state_reg <= BDT_IDLE;
          end
        end
        default: state_reg <= BDT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file write port: write-back, loads, restore
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rf_wr_en    <= 1'b0;
      rf_wr_idx   <= `BDT_RST_IDX;
      rf_wr_user  <= 1'b0;
      rf_wr_data  <= `BDT_RST_WORD;
      psr_restore <= 1'b0;
    end else begin
      rf_wr_en    <= 1'b0;
      psr_restore <= 1'b0;
      if (state_reg == BDT_FETCH) begin
        // committed at the end of the second cycle
        rf_wr_en   <= op_w;
        rf_wr_idx  <= base_idx;
        rf_wr_user <= 1'b0;
        rf_wr_data <= calc.wb_addr;
      end else if (state_reg == BDT_XFER && op_load) begin
        if (!ab_now) begin
          // a listed base is simply overwritten later
          // user bank when privileged and no program_counter
          rf_wr_en    <= 1'b1;
          rf_wr_idx   <= cur_idx_reg;
          rf_wr_user  <= op_s && !pc_listed;
          rf_wr_data  <= mem_rdata;
          // status restore with the program_counter write
          psr_restore <= op_s && cur_idx_reg == `BDT_PC_IDX;
        end else if (pend_reg == 16'h0000) begin
          // aborted loads never reach the file
          // port is free here, the last load was suppressed
          rf_wr_en   <= 1'b1;
          rf_wr_idx  <= base_idx;
          rf_wr_user <= 1'b0;
          rf_wr_data <= restore_val;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion, trap and status
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy           <= 1'b0;
      done           <= 1'b0;
      abort_trap     <= 1'b0;
      last_abort_reg <= 1'b0;
      cyc_reg        <= 8'h00;
      cyc_last_reg   <= 8'h00;
      lastbase_reg   <= `BDT_RST_WORD;
    end else begin
      done       <= 1'b0;
      abort_trap <= 1'b0;
      cyc_reg    <= (state_reg == BDT_IDLE) ? 8'h00 : cyc_reg + 8'h01;
      if (state_reg == BDT_IDLE && go_wr) begin
        busy <= hwdata[`BDT_CTRL_COND] && instr_reg[`BDT_LIST_MSB:0] != 16'h0000;
        done <= !(hwdata[`BDT_CTRL_COND] && instr_reg[`BDT_LIST_MSB:0] != 16'h0000);
      end
      if ((state_reg == BDT_INTERNAL && !(op_load && pc_listed && !abort_seen_reg))
          || (state_reg == BDT_REFILL && refill_reg == 2'h1)) begin
        // trap only once the instruction has finished
        busy           <= 1'b0;
        done           <= 1'b1;
        abort_trap     <= abort_seen_reg;
        last_abort_reg <= abort_seen_reg;
        cyc_last_reg   <= cyc_reg + 8'h01;
        lastbase_reg   <= op_w ? wb_reg : base_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [4:0] n_words;
  assign n_words = bdt_count(instr_reg[`BDT_LIST_MSB:0]);

  AST_COND_FALSE: assert property (go_wr && state_reg == BDT_IDLE && !hwdata[`BDT_CTRL_COND]
    |=> done ##0 (state_reg == BDT_IDLE && !mem_req) [*2]) else $error("failed condition ran");
  AST_ASCEND: assert property (state_reg == BDT_XFER && pend_reg != 16'h0000
    |=> mem_addr == $past(mem_addr) + `BDT_WORD_BYTES && cur_idx_reg > $past(cur_idx_reg))
    else $error("transfer order not ascending");
  AST_PC_STORE: assert property (mem_req && mem_we && cur_idx_reg == `BDT_PC_IDX
    |-> mem_wdata == iaddr_reg + `BDT_PC_STORE_OFS) else $error("bad stored pc value");
  AST_WB_SECOND: assert property (state_reg == BDT_FETCH && op_w
    |=> rf_wr_en && rf_wr_idx == base_idx && mem_req && rf_wr_data == wb_reg)
    else $error("write-back not in second cycle");
  AST_PSR_PC: assert property (psr_restore
    |-> rf_wr_en && rf_wr_idx == `BDT_PC_IDX && op_load && op_s) else $error("stray psr restore");
  AST_LOAD_STOP: assert property (state_reg == BDT_XFER && op_load && ab_now
    && pend_reg != 16'h0000 |=> !rf_wr_en) else $error("load after abort");
  AST_RESTORE: assert property (state_reg == BDT_XFER && op_load && ab_now
    && pend_reg == 16'h0000 |=> rf_wr_en && rf_wr_idx == base_idx && rf_wr_data == restore_val)
    else $error("base not restored");
  AST_CYCLES: assert property (done && $past(busy)
    |-> cyc_last_reg == {3'h0, n_words} + 8'h02 + ((op_load && pc_listed && !last_abort_reg)
    ? 8'h02 : 8'h00)) else $error("wrong cycle count");
  AST_USER_READ: assert property (state_reg == BDT_XFER
    |-> rf_rd_user == (op_s && !op_load)) else $error("wrong read bank");
  AST_STORE_TRAP: assert property (state_reg == BDT_XFER && !op_load && mem_abort
    ##1 state_reg == BDT_INTERNAL |=> done && abort_trap) else $error("store abort lost");

  COV_LOAD_PC: cover property (psr_restore ##[1:8] done);
  COV_STORE_ABORT: cover property (abort_trap && !op_load);
  COV_LOAD_ABORT: cover property (abort_trap && op_load);
  COV_COND_FALSE: cover property (go_wr && !hwdata[`BDT_CTRL_COND] ##1 done);

endmodule // bdt_seq

`default_nettype wire

// ==== bdt_params.svh ====
`ifndef BDT_PARAMS_SVH
`define BDT_PARAMS_SVH

// register map (byte addresses)
`define BDT_OFS_INSTR     8'h00
`define BDT_OFS_CTRL      8'h04
`define BDT_OFS_IADDR     8'h08
`define BDT_OFS_STATUS    8'h0C
`define BDT_OFS_LASTBASE  8'h10

// control and status fields
`define BDT_CTRL_GO       0
`define BDT_CTRL_COND     1
`define BDT_STAT_BUSY     0
`define BDT_STAT_ABORT    1
`define BDT_STAT_CYC_LSB  8

// instruction word fields
`define BDT_BIT_P         24
`define BDT_BIT_U         23
`define BDT_BIT_S         22
`define BDT_BIT_W         21
`define BDT_BIT_L         20
`define BDT_BASE_MSB      19
`define BDT_BASE_LSB      16
`define BDT_LIST_MSB      15

// reset values
`define BDT_RST_WORD      32'h0000_0000
`define BDT_RST_IDX       4'h0

// addressing and timing
`define BDT_PC_IDX        4'hF
`define BDT_WORD_BYTES    32'h0000_0004
`define BDT_PC_STORE_OFS  32'h0000_000C
`define BDT_REFILL_CYC    2'h2

`endif

// ==== bdt_pkg.sv ====
`include "bdt_params.svh"

package bdt_pkg;

  typedef logic [31:0] bdt_word_t;
  typedef logic [15:0] bdt_list_t;
  typedef logic [3:0]  bdt_idx_t;

  typedef enum logic [4:0] {
    BDT_IDLE     = 5'b00001,
    BDT_FETCH    = 5'b00010,
    BDT_XFER     = 5'b00100,
    BDT_INTERNAL = 5'b01000,
    BDT_REFILL   = 5'b10000
  } bdt_state_e;

  function automatic logic [4:0] bdt_count(input bdt_list_t list);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, list[i]};
    end
    return n;
  endfunction

  function automatic bdt_idx_t bdt_lowest(input bdt_list_t list);
    bdt_idx_t idx;
    idx = `BDT_RST_IDX;
    for (int i = 15; i >= 0; i--) begin
      if (list[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

endpackage

// ==== bdt_calc_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface bdt_calc_if;
  logic [31:0] base;
  logic [15:0] list;
  logic        pre;
  logic        up;
  logic [31:0] start_addr;
  logic [31:0] wb_addr;
  logic [4:0]  count;

  modport calc (input base, list, pre, up, output start_addr, wb_addr, count);
  modport seq  (output base, list, pre, up, input start_addr, wb_addr, count);
endinterface

`default_nettype wire

// ==== bdt_addr_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bdt_params.svh"

module bdt_addr_calc
  import bdt_pkg::*;
(
  bdt_calc_if.calc c
);

  logic [31:0] span;

  assign c.count = bdt_count(c.list);
  // span is 4n; the transfers always walk upward from the lowest address
  assign span    = {25'h000_0000, c.count, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // mode start addresses
  always_comb begin
    case ({c.pre, c.up})
      2'b01:   c.start_addr = c.base;
      2'b11:   c.start_addr = c.base + `BDT_WORD_BYTES;
      2'b00:   c.start_addr = c.base - span + `BDT_WORD_BYTES;
      default: c.start_addr = c.base - span;
    endcase
  end

  assign c.wb_addr = c.up ? (c.base + span) : (c.base - span);

endmodule // bdt_addr_calc

`default_nettype wire

// ==== bdt_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bdt_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_abort,
  input  wire logic        abort_en,
  input  wire logic [31:0] abort_addr
);
  logic [31:0] mem [256];
  logic [31:0] last;

  initial last = 32'h0000_0000;

  //////////////////////////////////////////////////
  // an idle bus shows the inverse of the last word, so stale data cannot pass
  assign mem_rdata = mem_req ? mem[mem_addr[9:2]] : ~last;
  // one chosen word faults, the rest of the block answers normally
  assign mem_abort = mem_req && abort_en && (mem_addr == abort_addr);

  always @(posedge clk_sys) begin
    if (mem_req) begin
      last <= mem_rdata;
      if (mem_we && !mem_abort) begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end
    end
  end
endmodule // bdt_mem_model

`default_nettype wire

// ==== test_block_register_transfer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bdt_params.svh"

module test_block_register_transfer;
  import bdt_pkg::*;
  logic        clk_sys, rst_b, hsel, hwrite, mem_abort, abort_en;
  logic        hreadyout, hresp, mem_req, mem_we, rf_rd_user, rf_wr_en, rf_wr_user;
  logic        psr_restore, busy, done, abort_trap;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, mem_rdata, rf_base_data, rf_rd_data, abort_addr, rng;
  bdt_word_t   hrdata, mem_addr, mem_wdata, rf_wr_data;
  bdt_idx_t    rf_base_idx, rf_rd_idx, rf_wr_idx;
  logic [31:0] rf [16], urf [16], erf [16], eurf [16], emem [256];
  logic [31:0] seen [$], want [$];
  int          failures, checked, psr_cnt;

  bdt_seq bdt_seq_inst (
    .clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_abort, .rf_base_idx, .rf_base_data, .rf_rd_idx, .rf_rd_user, .rf_rd_data,
    .rf_wr_en, .rf_wr_idx, .rf_wr_user, .rf_wr_data, .psr_restore, .busy, .done, .abort_trap
  );

  bdt_mem_model bdt_mem_model_inst (
    .clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_abort,
    .abort_en, .abort_addr
  );

  //////////////////////////////////////////////////
  // register file with both banks, read combinationally
  assign rf_base_data = rf[rf_base_idx];
  assign rf_rd_data   = rf_rd_user ? urf[rf_rd_idx] : rf[rf_rd_idx];

  always @(posedge clk_sys) begin
    if (mem_req === 1'b1) seen.push_back(mem_addr);
    if (rf_wr_en === 1'b1) begin
      if (rf_wr_user) urf[rf_wr_idx] <= rf_wr_data;
      else rf[rf_wr_idx] <= rf_wr_data;
    end
    if (psr_restore === 1'b1) psr_cnt++;
  end

  //////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single word transfer; waits on ready in both phases, no fixed latency assumed
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // i[2:0] selects load, before, increment; 8..15 user bank; 16..23 abort
  task automatic run(input logic [7:0] i);
    logic [31:0] base, start, wb, v, rd, iaddr;
    logic [15:0] list;
    logic        l, p, u, s, w, cond, usr;
    int          b, n, k, ab, t;
    l = i[2];
    p = i[1];
    u = i[0];
    s = (i[4:3] == 2'b01);
    cond = (i != 8'd25);
    rng = xs(rng);
    b = int'(rng[3:0]) % 15;
    w = rng[4] && !s;
    list = rng[31:16];
    list[15] = rng[5];
    if (list == 16'h0000) list[0] = 1'b1;
    usr = s && !(l && list[15]);
    rng = xs(rng);
    iaddr = {16'h0000, rng[31:18], 2'b00};
    base = 32'h0000_0200 + {24'h00_0000, rng[7:2], 2'b00};
    rf[b] = base;
    n = $countones(list);
    start = u ? (p ? base + 32'h4 : base) : base - 32'(4 * n) + (p ? 32'h0 : 32'h4);
    wb = u ? base + 32'(4 * n) : base - 32'(4 * n);
    ab = (i[4:3] == 2'b10) ? int'(rng[15:8]) % n : n;
    abort_en <= (ab < n);
    abort_addr <= start + 32'(4 * ab);
    erf = rf;
    eurf = urf;
    emem = bdt_mem_model_inst.mem;
    want.delete();
    seen.delete();
    psr_cnt = 0;
    if (cond) begin
      if (w) erf[b] = wb;
      k = 0;
      for (int r = 0; r < 16; r++) begin
        if (list[r]) begin
          v = start + 32'(4 * k);
          want.push_back(v);
          if (!l && k != ab) begin
            emem[v[9:2]] = r == 15 ? iaddr + 32'hC :
                           (usr ? urf[r] : (r == b && w && k > 0 ? wb : rf[r]));
          end
          if (l && k < ab && usr) eurf[r] = emem[v[9:2]];
          if (l && k < ab && !usr) erf[r] = emem[v[9:2]];
          k++;
        end
      end
      if (l && ab < n) erf[b] = w ? wb : base;
    end
    ahb(1'b1, `BDT_OFS_INSTR, {7'h00, p, u, s, w, l, 4'(b), list}, rd);
    ahb(1'b1, `BDT_OFS_IADDR, iaddr, rd);
    ahb(1'b1, `BDT_OFS_CTRL, {30'h0, cond, 1'b1}, rd);
    t = 0;
    while (done !== 1'b1 && t < 200) begin
      @(posedge clk_sys);
      t++;
    end
    chk("abort trap", {31'h0, cond && ab < n}, {31'h0, abort_trap});
    chk("done", 32'h0000_0001, {31'h0, done});
    chk("busy", 32'h0000_0000, {31'h0, busy});
    repeat (2) @(posedge clk_sys);
    ahb(1'b0, `BDT_OFS_STATUS, 32'h0, rd);
    chk("status flags", {30'h0, cond && ab < n, 1'b0}, {30'h0, rd[1:0]});
    t = n + 2 + ((l && list[15] && ab == n) ? 2 : 0);
    if (cond) chk("cycles", 32'(t), {24'h0, rd[15:8]});
    chk("transfers", 32'(want.size()), 32'(seen.size()));
    for (int j = 0; j < want.size() && j < seen.size(); j++) begin
      chk("address", want[j], seen[j]);
    end
    chk("status restore", {31'h0, cond && l && s && list[15] && ab == n}, 32'(psr_cnt));
    for (int j = 0; j < 16; j++) begin
      chk("register", erf[j], rf[j]);
      chk("user register", eurf[j], urf[j]);
    end
    for (int j = 0; j < 256; j++) begin
      chk("memory", emem[j], bdt_mem_model_inst.mem[j]);
    end
    $display("test %0d ended", i);
  endtask

  //////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // about 32 instructions of under 60 cycles each
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  initial begin
    logic [31:0] rd;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b000;
    hwdata = 32'h0;
    abort_en = 1'b0;
    abort_addr = 32'h0;
    failures = 0;
    checked = 0;
    psr_cnt = 0;
    rng = 32'd63;
    for (int j = 0; j < 16; j++) begin
      rng = xs(rng);
      rf[j] = rng;
      urf[j] = ~rng;
    end
    for (int j = 0; j < 256; j++) begin
      rng = xs(rng);
      bdt_mem_model_inst.mem[j] = rng;
    end
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, `BDT_OFS_STATUS, 32'h0, rd);
    chk("status after reset", 32'h0, rd);
    ahb(1'b0, 32'h0000_0040, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    for (int i = 0; i < 32; i++) run(8'(i));
    test_done();
  end
endmodule // test_block_register_transfer

`default_nettype wire
